// [hdl/lct_pkg.sv]
/*
 * Shared constants for the line timing generator of a four-line linear image sensor.
 * Assumes a single 25 MHz system clock and a synchronous, active-high reset.
 */
`default_nettype none

package lct_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int SYS_PERIOD_NS      = 40;
    localparam int SHIFT_MAX_MHZ      = 20;
    localparam int SHIFT_MIN_PERIOD_NS = 1000 / SHIFT_MAX_MHZ;
    // One pixel period is four quarters of one system cycle each.
    localparam int QUARTERS_PER_PIXEL = 4;
    localparam int PIXEL_PERIOD_NS    = QUARTERS_PER_PIXEL * SYS_PERIOD_NS;
    localparam int XFER_STEP_NS       = 1000;
    localparam int XFER_STEP_CYCLES   = (XFER_STEP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // ------------------------------------------------------------
    // Line geometry
    // ------------------------------------------------------------
    localparam logic [11:0] CHROMA_TOTAL  = 12'h8AE;  // 2222 periods
    localparam logic [11:0] CHROMA_ACTIVE = 12'h832;  // 2098 pixels
    localparam logic [11:0] CHROMA_LEAD   = 12'h000;
    localparam logic [12:0] LUMA_TOTAL    = 13'h1094; // 4244 periods
    localparam logic [12:0] LUMA_ACTIVE   = 13'h1064; // 4196 pixels
    localparam logic [12:0] LUMA_LEAD     = 13'h0000;

    // Positions within a pixel (quarter index) and a summed pair (pair index).
    localparam logic [1:0] Q_SAMPLE       = 2'h1;
    localparam logic [1:0] Q_RESET        = 2'h3;
    localparam logic [1:0] Q_PHASE_TWO    = 2'h2;
    localparam logic [2:0] PAIR_GATE_RISE = 3'h2;
    localparam logic [2:0] PAIR_RESET     = 3'h7;
    localparam logic [2:0] PAIR_SAMPLE    = 3'h1;

    localparam logic [4:0]  STEP_LAST  = 5'(XFER_STEP_CYCLES - 1);
    localparam logic [15:0] INT_RESET  = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_PARK,
        ST_GATES_ON,
        ST_FIRST_OFF,
        ST_SECOND_OFF
    } lct_state_t;

endpackage : lct_pkg

`default_nettype wire

// [hdl/lct_pixel_tick.sv]
/*
 * Pixel-period divider: walks the quarter index of the current pixel period.
 * Assumes its run input comes from logic on the same clock.
 */
`default_nettype none

module lct_pixel_tick (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_run,
    output logic [1:0]      o_quarter,
    output wire logic       o_pix_end
);
    import lct_pkg::*;

    logic [1:0] quarter_reg;

    assign o_quarter = quarter_reg;
    assign o_pix_end = i_run && (quarter_reg == 2'(QUARTERS_PER_PIXEL - 1));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_run) begin
            quarter_reg <= 2'h0;
        end else begin
            quarter_reg <= quarter_reg + 2'h1;
        end
    end

endmodule : lct_pixel_tick

`default_nettype wire

// [hdl/lct_line_timing.sv]
/*
 * Line timing generator driving the gates, phase clocks and reset clocks of a
 * four-line linear sensor, plus sample strobes for the analog front end.
 * Assumes all control inputs come from logic on the system clock.
 */
`default_nettype none

module lct_line_timing (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_enable,
    input  wire logic        i_sum_mode,
    input  wire logic [15:0] i_int_period,
    output logic             o_chroma_phase_one_clock,
    output logic             o_chroma_phase_two_clock,
    output logic             o_summing_gate_pin,
    output logic             o_chroma_reset_clock,
    output logic             o_chroma_first_gate_pin,
    output logic             o_chroma_second_gate_pin,
    output logic             o_luma_phase_one_clock,
    output logic             o_luma_phase_two_clock,
    output logic             o_luma_reset_clock,
    output logic             o_luma_gate_pin,
    output logic             o_chroma_sample,
    output logic             o_luma_sample,
    output logic             o_line_start,
    output logic             o_busy
);
    import lct_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lct_state_t  state_reg;
    lct_state_t  state_next;
    logic [4:0]  step_reg;
    logic [11:0] chroma_cnt_reg;
    logic [12:0] luma_cnt_reg;
    logic [15:0] int_cnt_reg;
    logic        sum_reg;

    logic [1:0]  quarter;
    logic        pix_end;
    wire  logic  reading    = (state_reg == ST_READ);
    wire  logic  step_done  = (step_reg == STEP_LAST);
    wire  logic  chroma_run = reading && (chroma_cnt_reg != CHROMA_TOTAL);
    wire  logic  luma_run   = reading && (luma_cnt_reg != LUMA_TOTAL);
    wire  logic  int_done   = (int_cnt_reg >= i_int_period);
    wire  logic  line_done  = !chroma_run && !luma_run;
    wire  logic  enter_read = (state_reg == ST_SECOND_OFF) && step_done;

    lct_pixel_tick u_tick (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_run     (reading),
        .o_quarter (quarter),
        .o_pix_end (pix_end)
    );

    // ------------------------------------------------------------
    // Transfer sequence
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_enable) begin
                    state_next = ST_PARK;
                end
            end
            ST_READ: begin
                if (line_done && !i_enable) begin
                    state_next = ST_IDLE;
                end else if (line_done && int_done) begin
                    state_next = ST_PARK;
                end
            end
            ST_PARK: begin
                if (step_done) begin
                    state_next = ST_GATES_ON;
                end
            end
            ST_GATES_ON: begin
                if (step_done) begin
                    state_next = ST_FIRST_OFF;
                end
            end
            ST_FIRST_OFF: begin
                if (step_done) begin
                    state_next = ST_SECOND_OFF;
                end
            end
            ST_SECOND_OFF: begin
                if (step_done) begin
                    state_next = ST_READ;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            step_reg  <= 5'h00;
        end else begin
            state_reg <= state_next;
            step_reg  <= (state_next != state_reg) ? 5'h00 : step_reg + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // Line and integration counters
    // ------------------------------------------------------------
    // Integration runs from the end of one transfer to the start of the next,
    // so it overlaps readout of the previous line.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            chroma_cnt_reg <= 12'h000;
            luma_cnt_reg   <= 13'h0000;
            int_cnt_reg    <= INT_RESET;
            sum_reg        <= 1'b0;
        end else if (enter_read) begin
            chroma_cnt_reg <= 12'h000;
            luma_cnt_reg   <= 13'h0000;
            int_cnt_reg    <= INT_RESET;
            sum_reg        <= i_sum_mode;
        end else if (pix_end) begin
            if (chroma_run) begin
                chroma_cnt_reg <= chroma_cnt_reg + 12'h001;
            end
            if (luma_run) begin
                luma_cnt_reg <= luma_cnt_reg + 13'h0001;
            end
            if (!int_done) begin
                int_cnt_reg <= int_cnt_reg + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Clock and gate pattern decoding
    // ------------------------------------------------------------
    // Phases are high for exactly two quarters each, which keeps them
    // symmetric; a stopped channel parks phase one high, phase two low.
    wire logic [2:0] pair_pos    = {chroma_cnt_reg[0], quarter};
    wire logic       p2_window   = (quarter >= Q_PHASE_TWO);
    wire logic       c_p1_next   = !chroma_run || !p2_window;
    wire logic       c_p2_next   = chroma_run && p2_window;
    wire logic       l_p1_next   = !luma_run || !p2_window;
    wire logic       l_p2_next   = luma_run && p2_window;
    // Summing gate holds six of eight quarters over a pixel pair.
    wire logic       sg_sum      = chroma_run && (pair_pos >= PAIR_GATE_RISE);
    wire logic       sg_next     = sum_reg ? sg_sum : c_p2_next;
    wire logic       c_rst_full  = chroma_run && (quarter == Q_RESET);
    wire logic       c_rst_sum   = chroma_run && (pair_pos == PAIR_RESET);
    wire logic       c_rst_next  = sum_reg ? c_rst_sum : c_rst_full;
    wire logic       l_rst_next  = luma_run && (quarter == Q_RESET);
    wire logic       c_in_active = (chroma_cnt_reg >= CHROMA_LEAD) &&
                                   (chroma_cnt_reg < CHROMA_LEAD + CHROMA_ACTIVE);
    wire logic       l_in_active = (luma_cnt_reg >= LUMA_LEAD) &&
                                   (luma_cnt_reg < LUMA_LEAD + LUMA_ACTIVE);
    wire logic       c_smp_next  = chroma_run && c_in_active &&
                                   (sum_reg ? (pair_pos == PAIR_SAMPLE) : (quarter == Q_SAMPLE));
    wire logic       l_smp_next  = luma_run && l_in_active && (quarter == Q_SAMPLE);
    // Gates stay at barrier everywhere except the two transfer steps ST_GATES_ON and ST_FIRST_OFF.
    wire logic       tg1_next    = (state_reg == ST_GATES_ON);
    wire logic       tg2_next    = (state_reg == ST_GATES_ON) ||
                                   (state_reg == ST_FIRST_OFF);
    wire logic       tgl_next    = (state_reg == ST_GATES_ON);

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_chroma_phase_one_clock <= 1'b1;
            o_chroma_phase_two_clock <= 1'b0;
            o_summing_gate_pin       <= 1'b0;
            o_chroma_reset_clock     <= 1'b0;
            o_luma_phase_one_clock   <= 1'b1;
            o_luma_phase_two_clock   <= 1'b0;
            o_luma_reset_clock       <= 1'b0;
            o_chroma_sample          <= 1'b0;
            o_luma_sample            <= 1'b0;
        end else begin
            o_chroma_phase_one_clock <= c_p1_next;
            o_chroma_phase_two_clock <= c_p2_next;
            o_summing_gate_pin       <= sg_next;
            o_chroma_reset_clock     <= c_rst_next;
            o_luma_phase_one_clock   <= l_p1_next;
            o_luma_phase_two_clock   <= l_p2_next;
            o_luma_reset_clock       <= l_rst_next;
            o_chroma_sample          <= c_smp_next;
            o_luma_sample            <= l_smp_next;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_chroma_first_gate_pin  <= 1'b0;
            o_chroma_second_gate_pin <= 1'b0;
            o_luma_gate_pin          <= 1'b0;
            o_line_start             <= 1'b0;
            o_busy                   <= 1'b0;
        end else begin
            o_chroma_first_gate_pin  <= tg1_next;
            o_chroma_second_gate_pin <= tg2_next;
            o_luma_gate_pin          <= tgl_next;
            o_line_start             <= enter_read;
            o_busy                   <= (state_next != ST_IDLE);
        end
    end

endmodule : lct_line_timing

`default_nettype wire

// [sim/lct_line_timing_sva.sv]
/* Concurrent checks on the line timing generator's pins.
   Assumes one system clock and a synchronous, active-high reset. */
`default_nettype none
module lct_line_timing_sva (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_sum_mode,
    input wire logic o_chroma_phase_one_clock,
    input wire logic o_chroma_phase_two_clock,
    input wire logic o_summing_gate_pin,
    input wire logic o_chroma_reset_clock,
    input wire logic o_chroma_first_gate_pin,
    input wire logic o_chroma_second_gate_pin,
    input wire logic o_luma_phase_one_clock,
    input wire logic o_luma_phase_two_clock,
    input wire logic o_luma_reset_clock,
    input wire logic o_luma_gate_pin,
    input wire logic o_line_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic [12:0] luma_rise_reg;
    logic [11:0] chroma_rise_reg;
    logic        seen_reg;
    logic        sum_prev_reg;
    logic        sum_line_reg;
    // The design latches the summing mode on the edge before the line start pulse, so the mode is
    // tracked here the same way and a change in mid-line is not mistaken for a pattern fault.
    wire  logic  line_sum = o_line_start ? sum_prev_reg : sum_line_reg;
    // Phase-two rises since the last line start give the clocked period count of each register.
    always_ff @(posedge i_clk_sys) begin
        seen_reg        <= !i_rst && (seen_reg || o_line_start);
        sum_prev_reg    <= i_sum_mode;
        sum_line_reg    <= !i_rst && line_sum;
        luma_rise_reg   <= (i_rst || o_line_start) ? 13'h0000 : luma_rise_reg + 13'($rose(o_luma_phase_two_clock));
        chroma_rise_reg <= (i_rst || o_line_start) ? 12'h000 : chroma_rise_reg + 12'($rose(o_chroma_phase_two_clock));
    end
    sequence parked;
        o_chroma_phase_one_clock && !o_chroma_phase_two_clock && o_luma_phase_one_clock && !o_luma_phase_two_clock;
    endsequence
    phases_compl_a: assert property (o_chroma_phase_one_clock != o_chroma_phase_two_clock)
        else $error("chroma phases not complementary");
    gates_parked_a: assert property ((o_chroma_first_gate_pin || o_chroma_second_gate_pin) |-> parked)
        else $error("gate on while shift clocks run");
    gates_on_a: assert property ($rose(o_chroma_first_gate_pin) |->
        ((o_chroma_second_gate_pin && o_luma_gate_pin) throughout ##24 1) ##1 !o_chroma_first_gate_pin)
        else $error("transfer gates not on together for 25 cycles");
    luma_single_a: assert property (o_luma_gate_pin |-> (o_chroma_first_gate_pin and parked))
        else $error("luma gate pulse outside the first gate step");
    first_off_a: assert property ($fell(o_chroma_first_gate_pin) |->
        (o_chroma_second_gate_pin throughout ##24 1) ##1 !o_chroma_second_gate_pin)
        else $error("second gate not held while first gate off");
    reisolate_a: assert property ($fell(o_chroma_second_gate_pin) |-> parked [*8])
        else $error("clocking restarted too soon after second gate");
    reset_dump_a: assert property (o_luma_reset_clock |-> o_luma_phase_two_clock ##1 !o_luma_phase_two_clock)
        else $error("luma reset not just before packet dump");
    phase_sym_a: assert property ($rose(o_luma_phase_two_clock) |->
        o_luma_phase_two_clock [*2] ##1 (!o_luma_phase_two_clock) [*2])
        else $error("luma phase two not symmetric");
    full_res_a: assert property (!line_sum |-> o_summing_gate_pin == o_chroma_phase_two_clock)
        else $error("summing gate differs from phase two");
    sum_duty_a: assert property (line_sum && $rose(o_summing_gate_pin) |->
        o_summing_gate_pin [*6] ##1 (!o_summing_gate_pin) [*2])
        else $error("summing gate duty wrong");
    sum_reset_a: assert property (line_sum && o_chroma_reset_clock |-> o_summing_gate_pin ##1 !o_summing_gate_pin)
        else $error("chroma reset not once per summed packet");
    line_count_a: assert property (o_line_start && seen_reg |->
        luma_rise_reg == 13'h1094 && chroma_rise_reg == 12'h8AE)
        else $error("line period count wrong");
endmodule : lct_line_timing_sva
bind lct_line_timing lct_line_timing_sva u_sva (.*);
`default_nettype wire

// [sim/lct_sensor_model.sv]
/* Behavioural charge path of the four-line sensor, counting packets dumped per channel.
   Assumes its pins are driven by the line timing generator. */
`default_nettype none
module lct_sensor_model (
    input  wire logic   i_chroma_phase_one_clock,
    input  wire logic   i_summing_gate_pin,
    input  wire logic   i_chroma_first_gate_pin,
    input  wire logic   i_chroma_second_gate_pin,
    input  wire logic   i_luma_phase_two_clock,
    output logic        o_luma_pair_valid,
    output logic [15:0] o_chroma_packets,
    output logic [15:0] o_luma_packets,
    output logic [15:0] o_lines_captured
);
    timeunit 1ns;
    timeprecision 1ps;
    logic charge_held;
    initial {charge_held, o_chroma_packets, o_luma_packets, o_lines_captured} = '0;
    assign o_luma_pair_valid = !i_luma_phase_two_clock;
    // Both gates switch on the same clock edge, so the second gate is looked at a moment later.
    always @(posedge i_chroma_first_gate_pin) #1 charge_held = i_chroma_second_gate_pin;
    // Charge is lost unless the second gate is still open and the register parked as the first closes.
    always @(negedge i_chroma_first_gate_pin) begin
        if (charge_held && i_chroma_second_gate_pin && i_chroma_phase_one_clock) begin
            o_lines_captured = o_lines_captured + 16'h0001;
        end
        charge_held = 1'b0;
    end
    always @(negedge i_summing_gate_pin) o_chroma_packets = o_chroma_packets + 16'h0001;
    always @(negedge i_luma_phase_two_clock) o_luma_packets = o_luma_packets + 16'h0001;
endmodule : lct_sensor_model
`default_nettype wire

// [sim/linear_ccd_line_timing_tb.sv]
/* Self-checking bench for the line timing generator with the sensor model on its pins.
   Assumes the checker is bound onto the design. */
`default_nettype none
module linear_ccd_line_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_enable = 1'b0, i_sum_mode = 1'b0;
    logic [15:0] i_int_period = 16'h0001;
    logic o_chroma_phase_one_clock, o_chroma_phase_two_clock, o_summing_gate_pin, o_chroma_reset_clock;
    logic o_chroma_first_gate_pin, o_chroma_second_gate_pin, o_luma_phase_one_clock, o_luma_phase_two_clock;
    logic o_luma_reset_clock, o_luma_gate_pin, o_chroma_sample, o_luma_sample, o_line_start, o_busy;
    logic [15:0] chroma_pk, luma_pk, captured;
    logic        luma_pair_valid;
    int fails = 0, samples_checked = 0;
    int n_cr, n_lr, n_cs, n_ls, n_cyc, n_cpk, n_lpk;
    lct_line_timing uut (.*);
    lct_sensor_model u_model (.i_chroma_phase_one_clock(o_chroma_phase_one_clock),
        .i_summing_gate_pin(o_summing_gate_pin), .i_chroma_first_gate_pin(o_chroma_first_gate_pin),
        .i_chroma_second_gate_pin(o_chroma_second_gate_pin), .i_luma_phase_two_clock(o_luma_phase_two_clock),
        .o_luma_pair_valid(luma_pair_valid), .o_chroma_packets(chroma_pk), .o_luma_packets(luma_pk),
        .o_lines_captured(captured));
    initial forever #20 i_clk_sys = ~i_clk_sys;
    task automatic check(input string what, input int exp, input int got);
        samples_checked++;
        if (exp != got) begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic wait_start();
        for (int i = 0; i < 30000 && o_line_start !== 1'b1; i++) @(negedge i_clk_sys);
        check("line start seen", 1, int'(o_line_start === 1'b1));
        if (o_line_start !== 1'b1) report_and_stop();
    endtask : wait_start
    // Counts strobes and packets until the next line start or until the block goes idle.
    task automatic run_line();
        int c0, l0;
        c0 = chroma_pk;
        l0 = luma_pk;
        {n_cr, n_lr, n_cs, n_ls, n_cyc} = '0;
        do begin
            @(negedge i_clk_sys);
            n_cyc++;
            n_cr += int'(o_chroma_reset_clock === 1'b1);
            n_lr += int'(o_luma_reset_clock === 1'b1);
            n_cs += int'(o_chroma_sample === 1'b1);
            n_ls += int'(o_luma_sample === 1'b1 && luma_pair_valid === 1'b1);
        end while (o_line_start !== 1'b1 && o_busy === 1'b1 && n_cyc < 40000);
        check("line bounded", 1, int'(n_cyc < 40000));
        if (n_cyc >= 40000) report_and_stop();
        n_cpk = int'(chroma_pk) - c0;
        n_lpk = int'(luma_pk) - l0;
    endtask : run_line
    task automatic t_reset();
        @(negedge i_clk_sys);
        check("reset outputs", 1, int'({o_chroma_phase_one_clock, o_luma_phase_one_clock, o_chroma_phase_two_clock,
            o_luma_gate_pin, o_chroma_first_gate_pin, o_busy, o_line_start} === 7'h60));
        $display("reset test done");
    endtask : t_reset
    task automatic t_full_line();
        int cap0;
        cap0 = captured;
        i_enable = 1'b1;
        wait_start();
        check("lines captured", 1, int'(captured) - cap0);
        i_enable = 1'b0;
        run_line();
        check("chroma resets", 2222, n_cr);
        check("luma resets", 4244, n_lr);
        check("chroma samples", 2098, n_cs);
        check("luma samples", 4196, n_ls);
        check("chroma packets", 2222, n_cpk);
        check("luma packets", 4244, n_lpk);
        check("ran to line end", 1, int'(n_cyc >= 16976 && o_busy === 1'b0));
        $display("full resolution test done");
    endtask : t_full_line
    task automatic t_sum_line();
        i_sum_mode = 1'b1;
        i_enable = 1'b1;
        wait_start();
        run_line();
        check("summed samples", 1049, n_cs);
        check("summed resets", 1111, n_cr);
        check("summed packets", 1111, n_cpk);
        check("luma resets", 4244, n_lr);
        check("line spacing", 1, int'(n_cyc >= 16976));
        i_int_period = 16'h1200;
        run_line();
        check("long integration", 1, int'(n_cyc >= 18432 && n_cyc < 18732));
        i_enable = 1'b0;
        $display("summing and integration test done");
    endtask : t_sum_line
    initial begin
        repeat (6) @(negedge i_clk_sys);
        i_rst = 1'b0;
        t_reset();
        t_full_line();
        t_sum_line();
        report_and_stop();
    end
endmodule : linear_ccd_line_timing_tb
`default_nettype wire
